/* File: tch_host_regs.sv */
/*
 * host register bank and front-end control of the touch controller.
 * assumes sensing logic on clk_sys_i and a host on the two-wire pins.
 */
`default_nettype none
module tch_host_regs #(
    parameter int   N_SENSORS   = 12,
    parameter int   SCAN_CYCLES = tch_pkg::SCAN_CYCLES,
    parameter logic TEN_PORT    = 1'b0
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    input  wire logic                 clk_link_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    input  wire logic [7:0]           pwm_flash_done_set_i,
    input  wire logic [N_SENSORS-1:0] over_thr_i,
    input  wire logic [N_SENSORS-1:0] cont_touch_i,
    input  wire logic [N_SENSORS-1:0] stuck_excess_i,
    input  wire logic [N_SENSORS-1:0] switch_off_clr_i,
    input  wire logic                 periodic_active_i,
    input  wire logic                 overflow_i,
    output logic                      scl_o,
    output logic                      scl_oe_n_o,
    output logic                      sda_o,
    output logic                      sda_oe_n_o,
    output logic                      scan_on_o,
    output logic                      config_apply_o,
    output logic                      stuck_release_o,
    output logic                      overflow_retune_off_o,
    output logic                      self_tune_req_o,
    output logic [$clog2(N_SENSORS)-1:0] sensor_sel_o,
    output logic                      measure_o,
    output logic                      decide_o,
    output logic                      tune_active_o,
    output logic [N_SENSORS-1:0]      tune_mask_o,
    output logic [N_SENSORS-1:0]      force_off_o,
    output logic [N_SENSORS-1:0]      switch_off_flag_o,
    output logic [7:0]                pwm_flash_done_o,
    output logic                      int_o
);
    localparam int SLOT_CYCLES = SCAN_CYCLES / N_SENSORS;
    localparam int SW = $clog2(SLOT_CYCLES);
    localparam int IW = $clog2(N_SENSORS);
    localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);
    localparam logic [IW-1:0] IDX_LAST  = IW'(N_SENSORS - 1);

    if (N_SENSORS < 2 || N_SENSORS > 16 || SLOT_CYCLES < 4) begin : g_chk
        $error("tch_host_regs: sensor count or scan length out of range");
    end

    logic       link_req, link_we, ack_tgl_reg, zero_reg;
    logic [7:0] link_addr, link_wdata, rdata_reg, rd_next;
    logic [2:0] req_s;
    logic       req_evt, wr_fec, tune_start, scan_end, copy_pend_reg;
    logic [7:0] pwm_clr_reg, check_reg, readback_reg, fec_reg;
    logic [SW-1:0] slot_reg;
    tch_pkg::tch_tune_t tune_state;

    function automatic logic wr_to(input logic ev, input logic we,
                                   input logic [7:0] a, input logic [7:0] target);
        wr_to = ev & we & (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link side runs on its own clock; words cross by toggle handshake
    tch_i2c_link #(
        .SLAVE_ADDR(TEN_PORT ? tch_pkg::SLAVE_ADDR_TEN : tch_pkg::SLAVE_ADDR_TWELVE)
    ) u_link (
        .clk_link_i(clk_link_i),
        .rstn_i    (rstn_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .ack_tgl_i (ack_tgl_reg),
        .rdata_i   (rdata_reg),
        .req_tgl_o (link_req),
        .we_o      (link_we),
        .addr_o    (link_addr),
        .wdata_o   (link_wdata),
        .sda_oe_n_o(sda_oe_n_o),
        .scl_oe_n_o(scl_oe_n_o)
    );

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i)
            zero_reg <= 1'b0;
        else
            zero_reg <= 1'b0;
    end
    assign sda_o = zero_reg;
    assign scl_o = zero_reg;

    // fields stay still while the request is open, so only the toggle is synced
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i)
            req_s <= 3'h0;
        else
            req_s <= {req_s[1:0], link_req};
    end
    assign req_evt = req_s[2] ^ req_s[1];

    always_comb begin
        case (link_addr)
            tch_pkg::ADR_STATUS:   rd_next = {6'h00, int_o, 1'b0};
            tch_pkg::ADR_READBACK: rd_next = readback_reg;
            tch_pkg::ADR_PWM_CLR:  rd_next = pwm_clr_reg;
            tch_pkg::ADR_CHECK:    rd_next = check_reg;
            tch_pkg::ADR_FEC:      rd_next = fec_reg;
            default:               rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rdata_reg <= 8'h00;
            ack_tgl_reg <= 1'b0;
        end else if (req_evt) begin
            if (!link_we)
                rdata_reg <= rd_next; // one byte per address n, n+1..
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pwm_clr_reg <= tch_pkg::RST_BYTE;
            pwm_flash_done_o <= tch_pkg::RST_BYTE;
        end else begin
            if (wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_PWM_CLR))
                pwm_clr_reg <= link_wdata;
            // a done event in the clearing cycle survives
            pwm_flash_done_o <= (pwm_flash_done_o &
                (wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_PWM_CLR) ?
                 link_wdata : 8'hff)) | pwm_flash_done_set_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            check_reg <= tch_pkg::RST_BYTE;
            readback_reg <= tch_pkg::RST_BYTE;
            copy_pend_reg <= 1'b0;
        end else begin
            copy_pend_reg <= wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_CHECK);
            if (wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_CHECK))
                check_reg <= link_wdata;
            if (copy_pend_reg)
                readback_reg <= check_reg;
        end
    end

    assign wr_fec = wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_FEC);
    assign tune_start = wr_fec & link_wdata[tch_pkg::FEC_TUNE];

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            fec_reg <= tch_pkg::RST_BYTE;
            config_apply_o <= 1'b0;
            stuck_release_o <= 1'b0;
            overflow_retune_off_o <= 1'b0;
        end else begin
            config_apply_o <= wr_fec & link_wdata[tch_pkg::FEC_APPLY];
            if (wr_fec)
                fec_reg <= link_wdata & tch_pkg::FEC_MASK;
            // staged bits only reach the logic on apply
            if (wr_fec && link_wdata[tch_pkg::FEC_APPLY]) begin
                stuck_release_o <= link_wdata[tch_pkg::FEC_REL];
                overflow_retune_off_o <= link_wdata[tch_pkg::FEC_OVF];
            end
        end
    end
    assign scan_on_o = fec_reg[tch_pkg::FEC_SCAN];

    ////////////////////////////////////////////////////////////////////////////
    // equal slots per sensor; fewer sensors simply get longer slots
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || !scan_on_o) begin
            slot_reg <= '0;
            sensor_sel_o <= '0;
            measure_o <= 1'b0;
            decide_o <= 1'b0;
        end else begin
            measure_o <= (slot_reg == '0);
            decide_o <= scan_end;
            if (slot_reg == SLOT_LAST) begin
                slot_reg <= '0;
                sensor_sel_o <= (sensor_sel_o == IDX_LAST) ? '0 : sensor_sel_o + 1'b1;
            end else
                slot_reg <= slot_reg + 1'b1;
        end
    end
    assign scan_end = scan_on_o & (slot_reg == SLOT_LAST) & (sensor_sel_o == IDX_LAST);

    // a start mid-scan waits for the next whole scan
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i)
            tune_state <= tch_pkg::TU_IDLE;
        else begin
            case (tune_state)
                tch_pkg::TU_IDLE: if (tune_start) tune_state <= tch_pkg::TU_WAIT;
                tch_pkg::TU_WAIT:
                    if (scan_on_o && slot_reg == '0 && sensor_sel_o == '0)
                        tune_state <= tch_pkg::TU_RUN;
                tch_pkg::TU_RUN: if (scan_end) tune_state <= tch_pkg::TU_IDLE;
                default: tune_state <= tch_pkg::TU_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            int_o <= 1'b0;
            tune_active_o <= 1'b0;
        end else begin
            tune_active_o <= (tune_state == tch_pkg::TU_RUN);
            // finish wins over a clear in the same cycle
            if (tune_state == tch_pkg::TU_RUN && scan_end)
                int_o <= 1'b1;
            else if (wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_IRQ_CLR) &&
                     !link_wdata[tch_pkg::ST_TUNE_DONE])
                int_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            tune_mask_o <= '0;
            force_off_o <= '0;
            switch_off_flag_o <= '0;
            self_tune_req_o <= 1'b0;
        end else begin
            tune_mask_o <= fec_reg[tch_pkg::FEC_SCOPE] ? ~over_thr_i : '1;
            force_off_o <= ((tune_state == tch_pkg::TU_RUN &&
                             !fec_reg[tch_pkg::FEC_SCOPE]) ? over_thr_i : '0)
                         | (stuck_release_o ? (cont_touch_i & stuck_excess_i) : '0);
            switch_off_flag_o <= (switch_off_flag_o & ~switch_off_clr_i) | force_off_o;
            self_tune_req_o <= periodic_active_i & overflow_i & ~overflow_retune_off_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    pwm_clear_a: assert property (
        wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_PWM_CLR) && pwm_flash_done_set_i == '0
        |=> pwm_flash_done_o == ($past(pwm_flash_done_o) & $past(link_wdata)))
        else $error("pwm done flag not cleared as written");
    readback_copy_a: assert property (
        wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_CHECK)
        |-> ##2 readback_reg == $past(link_wdata, 2))
        else $error("check value not copied to readback");
    scan_enable_a: assert property (
        wr_fec |=> scan_on_o == $past(link_wdata[tch_pkg::FEC_SCAN]))
        else $error("scan enable does not follow write");
    tune_start_a: assert property (
        tune_start && tune_state == tch_pkg::TU_IDLE |=> tune_state == tch_pkg::TU_WAIT)
        else $error("calibration did not start");
    apply_hold_a: assert property (
        !(wr_fec && link_wdata[tch_pkg::FEC_APPLY]) |=> $stable(stuck_release_o)
        && $stable(overflow_retune_off_o))
        else $error("staged bit took effect without apply");
    scope_all_a: assert property (
        tune_state == tch_pkg::TU_RUN && !fec_reg[tch_pkg::FEC_SCOPE]
        |=> (force_off_o & $past(over_thr_i)) == $past(over_thr_i) ##1
        (switch_off_flag_o & $past(over_thr_i, 2)) == $past(over_thr_i, 2))
        else $error("sensor above threshold not forced off");
    scope_skip_a: assert property (
        fec_reg[tch_pkg::FEC_SCOPE] |=> (tune_mask_o & $past(over_thr_i)) == '0)
        else $error("sensor above threshold still tuned");
    overflow_a: assert property (
        periodic_active_i && overflow_i && !overflow_retune_off_o |=> self_tune_req_o)
        else $error("overflow self calibration missing");
    release_a: assert property (
        !stuck_release_o && tune_state != tch_pkg::TU_RUN |=> force_off_o == '0)
        else $error("force off without release enabled");
    decide_after_a: assert property (
        decide_o |-> $past(sensor_sel_o) == IDX_LAST && sensor_sel_o == '0)
        else $error("decision before last sensor measured");
    tune_done_a: assert property (
        tune_state == tch_pkg::TU_RUN && scan_end |=> int_o && tune_state == tch_pkg::TU_IDLE)
        else $error("finish flag not raised after calibration");

    cover_write_c: cover property (wr_to(req_evt, link_we, link_addr, tch_pkg::ADR_CHECK));
    cover_read_c: cover property (req_evt && !link_we ##[1:100] req_evt && !link_we);
    cover_tune_c: cover property (tune_state == tch_pkg::TU_RUN ##1 int_o);
    cover_force_c: cover property (stuck_release_o && force_off_o != '0);
endmodule
`default_nettype wire

/* File: tch_pkg.sv */
/*
 * shared constants and types of the touch controller host block.
 * assumes a 50 mhz system clock and a free-running link sampling clock.
 */
`default_nettype none
package tch_pkg;
    localparam logic [7:0] ADR_STATUS   = 8'h10;
    localparam logic [7:0] ADR_READBACK = 8'h1e;
    localparam logic [7:0] ADR_IRQ_CLR  = 8'hf0;
    localparam logic [7:0] ADR_PWM_CLR  = 8'hfb;
    localparam logic [7:0] ADR_CHECK    = 8'hfe;
    localparam logic [7:0] ADR_FEC      = 8'hff;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] FEC_MASK     = 8'hd7;
    localparam int FEC_SCAN  = 0;
    localparam int FEC_TUNE  = 1;
    localparam int FEC_APPLY = 2;
    localparam int FEC_SCOPE = 4;
    localparam int FEC_OVF   = 6;
    localparam int FEC_REL   = 7;
    localparam int ST_TUNE_DONE = 1;
    localparam logic [6:0] SLAVE_ADDR_TEN    = 7'h5c;
    localparam logic [6:0] SLAVE_ADDR_TWELVE = 7'h5d;
    localparam int SM_KBPS = 100;
    localparam int FM_KBPS = 400;
    localparam int SCAN_TIME_US = 16000;
    localparam int SYS_CLK_MHZ  = 50;
    localparam int SCAN_CYCLES  = SCAN_TIME_US * SYS_CLK_MHZ;
    typedef enum logic [1:0] {TU_IDLE, TU_WAIT, TU_RUN} tch_tune_t;
    typedef enum logic [2:0] {LM_IDLE, LM_DEV, LM_REG, LM_WR, LM_RD} tch_lmode_t;
endpackage
`default_nettype wire

/* File: tch_i2c_link.sv */
/*
 * two-wire slave on the link clock: byte write, random and sequential read.
 * assumes the link clock runs at least 16x the bus bit rate.
 */
`default_nettype none
module tch_i2c_link #(
    parameter logic [6:0] SLAVE_ADDR = tch_pkg::SLAVE_ADDR_TWELVE
) (
    input  wire logic       clk_link_i,
    input  wire logic       rstn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       ack_tgl_i,
    input  wire logic [7:0] rdata_i,
    output logic            req_tgl_o,
    output logic            we_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            sda_oe_n_o,
    output logic            scl_oe_n_o
);
    logic [1:0] rst_s;
    logic [2:0] scl_s, sda_s, ack_s;
    logic       rstn_l, rise, fall, start, stop, ack_evt;
    tch_pkg::tch_lmode_t mode;
    logic [3:0] bitc;
    logic [7:0] sh, ptr;
    logic       nack, pend, busy;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_link_i) begin
        rst_s <= {rst_s[0], rstn_i};
    end
    assign rstn_l = rst_s[1];

    // oversampled pins; stage 0 only feeds stage 1
    always_ff @(posedge clk_link_i) begin
        if (!rstn_l) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            ack_s <= 3'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
            ack_s <= {ack_s[1:0], ack_tgl_i};
        end
    end
    assign rise    = scl_s[1] & ~scl_s[2];
    assign fall    = ~scl_s[1] & scl_s[2];
    assign start   = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop    = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    assign ack_evt = ack_s[1] ^ ack_s[2];

    ////////////////////////////////////////////////////////////////////////////
    // slave only: never drives a start or clocks of its own
    always_ff @(posedge clk_link_i) begin
        if (!rstn_l) begin
            mode <= tch_pkg::LM_IDLE;
            bitc <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            nack <= 1'b0;
            pend <= 1'b0;
            busy <= 1'b0;
            req_tgl_o <= 1'b0;
            we_o <= 1'b0;
            addr_o <= 8'h00;
            wdata_o <= 8'h00;
            sda_oe_n_o <= 1'b1;
            scl_oe_n_o <= 1'b1;
        end else begin
            if (ack_evt)
                busy <= 1'b0;
            if (start) begin
                mode <= tch_pkg::LM_DEV;
                bitc <= 4'h0;
                nack <= 1'b0;
                pend <= 1'b0;
                sda_oe_n_o <= 1'b1;
                scl_oe_n_o <= 1'b1;
            end else if (stop) begin
                mode <= tch_pkg::LM_IDLE;
                pend <= 1'b0;
                sda_oe_n_o <= 1'b1;
                scl_oe_n_o <= 1'b1;
            end else if (pend) begin
                // clock held low until the fetched byte is back
                if (!busy) begin
                    sh <= rdata_i;
                    sda_oe_n_o <= rdata_i[7];
                    scl_oe_n_o <= 1'b1;
                    pend <= 1'b0;
                end
            end else if (rise) begin
                if (bitc < 4'h8) begin
                    sh <= {sh[6:0], sda_s[1]};
                    bitc <= bitc + 4'h1;
                end else if (bitc == 4'h9 && mode == tch_pkg::LM_RD)
                    nack <= sda_s[1];
            end else if (fall && mode != tch_pkg::LM_IDLE) begin
                if (bitc == 4'h8) begin
                    bitc <= 4'h9;
                    sda_oe_n_o <= 1'b1;
                    case (mode)
                        tch_pkg::LM_DEV: begin
                            if (sh[7:1] == SLAVE_ADDR) begin
                                sda_oe_n_o <= 1'b0;
                                if (sh[0]) begin
                                    mode <= tch_pkg::LM_RD;
                                    we_o <= 1'b0; // fetch byte n
                                    addr_o <= ptr;
                                    ptr <= ptr + 8'h01;
                                    req_tgl_o <= ~req_tgl_o;
                                    busy <= 1'b1;
                                end else
                                    mode <= tch_pkg::LM_REG;
                            end else
                                mode <= tch_pkg::LM_IDLE;
                        end
                        tch_pkg::LM_REG: begin
                            sda_oe_n_o <= 1'b0;
                            ptr <= sh;
                            mode <= tch_pkg::LM_WR;
                        end
                        tch_pkg::LM_WR: begin
                            sda_oe_n_o <= 1'b0; // byte write, acked
                            we_o <= 1'b1;
                            addr_o <= ptr;
                            wdata_o <= sh;
                            ptr <= ptr + 8'h01;
                            req_tgl_o <= ~req_tgl_o;
                            busy <= 1'b1;
                        end
                        tch_pkg::LM_RD: begin
                            // prefetch n+1 while the master acks
                            we_o <= 1'b0;
                            addr_o <= ptr;
                            ptr <= ptr + 8'h01;
                            req_tgl_o <= ~req_tgl_o;
                            busy <= 1'b1;
                        end
                        default: ;
                    endcase
                end else if (bitc == 4'h9) begin
                    bitc <= 4'h0;
                    sda_oe_n_o <= 1'b1;
                    if (mode == tch_pkg::LM_RD) begin
                        if (nack)
                            mode <= tch_pkg::LM_IDLE; // nack ends a read
                        else begin
                            pend <= 1'b1;
                            scl_oe_n_o <= 1'b0;
                        end
                    end
                end else if (mode == tch_pkg::LM_RD)
                    sda_oe_n_o <= sh[7]; // sh rotates back in from the wire on each rise
            end
        end
    end
endmodule
`default_nettype wire

/* File: tch_host_model.sv */
/* host model: two-wire master with bit, byte, start and stop tasks.
   assumes open-drain wires whose pull-up level the bench resolves. */
`default_nettype none
module tch_host_model (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_dn_o,
    output logic      sda_dn_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 625; // 2.5 us bit keeps fast mode
    initial begin
        scl_dn_o = 1'b0;
        sda_dn_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic bit_io(input logic b, output logic r);
        sda_dn_o = !b;
        #Q scl_dn_o = 1'b0;
        // slave may stretch scl; bounded so a stuck wire cannot hang us
        for (int n = 0; n < 99 && !scl_i; n++) #50;
        #Q r = sda_i;
        #Q scl_dn_o = 1'b1;
        #Q;
    endtask
    task automatic start();
        sda_dn_o = 1'b0;
        #Q scl_dn_o = 1'b0;
        #Q sda_dn_o = 1'b1;
        #Q scl_dn_o = 1'b1;
        #Q;
    endtask
    task automatic stop();
        sda_dn_o = 1'b1;
        #Q scl_dn_o = 1'b0;
        #Q sda_dn_o = 1'b0;
        #(3 * Q);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic k);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]); // msb first
        bit_io(a, k);
    endtask
endmodule
`default_nettype wire

/* File: test_touch_ctrl_host_regs.sv */
/* bench of the host register block driven through its two-wire port.
   assumes tch_host_model as host and pull-ups on both wires. */
`default_nettype none
`define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module test_touch_ctrl_host_regs;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] AW = {tch_pkg::SLAVE_ADDR_TWELVE, 1'b0};
    logic        clk_sys_i = 1'b0, clk_link_i = 1'b0, rstn_i = 1'b0;
    logic        periodic_active_i = 1'b1, overflow_i = 1'b1;
    logic [7:0]  pwm_flash_done_set_i = 8'h00, pwm_flash_done_o, x;
    logic [11:0] cont_touch_i = 12'h001, stuck_excess_i = 12'h001;
    logic [11:0] force_off_o, switch_off_flag_o;
    logic [11:0] over_thr_i = 12'h000, tune_mask_o;
    logic        scl_oe_n_o, sda_oe_n_o, scan_on_o, stuck_release_o, int_o, k;
    logic        overflow_retune_off_o, self_tune_req_o, scl_dn_o, sda_dn_o;
    logic [15:0] q;
    logic [7:0]  ra [4] = '{8'hfb, 8'hfe, 8'hff, 8'h10};
    int          n_mismatch = 0, comparisons = 0;
    wire logic   scl_i = !(scl_dn_o || !scl_oe_n_o);
    wire logic   sda_i = !(sda_dn_o || !sda_oe_n_o);
    always #10 clk_sys_i = ~clk_sys_i;
    always #62.5 clk_link_i = ~clk_link_i;
    tch_host_regs #(.N_SENSORS(12), .SCAN_CYCLES(96)) u_dut (.clk_sys_i, .rstn_i,
        .clk_link_i, .scl_i, .sda_i, .pwm_flash_done_set_i, .over_thr_i,
        .cont_touch_i, .stuck_excess_i, .switch_off_clr_i(12'h000), .periodic_active_i,
        .overflow_i, .scl_o(), .scl_oe_n_o, .sda_o(), .sda_oe_n_o, .scan_on_o,
        .config_apply_o(), .stuck_release_o, .overflow_retune_off_o, .self_tune_req_o,
        .sensor_sel_o(), .measure_o(), .decide_o(), .tune_active_o(), .tune_mask_o,
        .force_off_o, .switch_off_flag_o, .pwm_flash_done_o, .int_o);
    tch_host_model u_host (.scl_i, .sda_i, .scl_dn_o, .sda_dn_o);
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.start();
        u_host.xfer(AW, 1'b1, x, k);
        `CHK(k, 1'b0)
        u_host.xfer(a, 1'b1, x, k);
        u_host.xfer(d, 1'b1, x, k);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        q = 16'h0000;
        u_host.start();
        u_host.xfer(AW, 1'b1, x, k);
        u_host.xfer(a, 1'b1, x, k);
        u_host.start();
        u_host.xfer(AW | 8'h01, 1'b1, x, k);
        `CHK(k, 1'b0)
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'hff, i == n - 1, x, k); // nack ends the read
            q = {q[7:0], x};
        end
        u_host.stop();
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        // link resync needs four link edges, longer than three sys cycles
        repeat (4) @(posedge clk_link_i);
        @(negedge clk_sys_i) rstn_i = 1'b1;
        repeat (4) @(posedge clk_link_i);
        // wire changes then fall off the link sampling edge
        @(negedge clk_link_i);
        foreach (ra[i]) begin
            rd(ra[i], 1);
            `CHK(q[7:0], 8'h00)
        end
        wr(8'hfe, 8'ha5);
        rd(8'h1e, 1);
        `CHK(q[7:0], 8'ha5)
        u_host.start();
        u_host.xfer({tch_pkg::SLAVE_ADDR_TEN, 1'b0}, 1'b1, x, k);
        u_host.stop();
        `CHK(k, 1'b1)
        wr(8'hff, 8'hc1);
        `CHK(({scan_on_o, self_tune_req_o}), 2'b11)
        `CHK(({stuck_release_o, overflow_retune_off_o, force_off_o[0]}), 3'b000)
        wr(8'hff, 8'hc5);
        `CHK(({stuck_release_o, overflow_retune_off_o}), 2'b11)
        `CHK(({self_tune_req_o, force_off_o[0], switch_off_flag_o[0]}), 3'b011)
        rd(8'hfe, 2);
        `CHK(q, 16'ha5c5)
        @(negedge clk_sys_i) pwm_flash_done_set_i = 8'hff;
        @(negedge clk_sys_i) pwm_flash_done_set_i = 8'h00;
        `CHK(pwm_flash_done_o, 8'hff)
        wr(8'hfb, 8'h0f);
        `CHK(pwm_flash_done_o, 8'h0f)
        wr(8'hff, 8'h03);
        for (int i = 0; i < 999 && int_o !== 1'b1; i++) @(negedge clk_sys_i);
        `CHK(int_o, 1'b1)
        wr(8'hff, 8'h01);
        rd(8'h10, 1);
        `CHK(q[7:0], 8'h02)
        wr(8'hf0, 8'h00);
        `CHK(int_o, 1'b0)
        @(negedge clk_sys_i) over_thr_i = 12'h002;
        wr(8'hff, 8'h13);
        `CHK(tune_mask_o[1:0], 2'b01)
        wr(8'hff, 8'h07);
        repeat (200) @(negedge clk_sys_i);
        `CHK(({force_off_o[1], switch_off_flag_o[1]}), 2'b01)
        end_of_test();
    end
    initial begin
        #1900000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
